// ---- hw/ddlo_dll_core.sv ----
`timescale 1ns/1ns
// How it works
// R1: Chip select high blocks new commands
// R2: MR1 A0 set disables DLL until cleared
// R3: DLL bit may change at any time; MR1 writes here are taken only with commands enabled and outside self refresh
// R4: Controller keeps clock below DLL-off maximum
// R5: DLL-off supports only CL6 with CWL6
// R6: DLL-off read timing starts at AL+CL-1
// R7: Strobe and data shift together, skew unchanged
// R8: Controller tolerates large, wide strobe delay
// R9: Controller idles banks, termination off first
// R10: Controller follows DLL-off switching order
// R11: Controller holds CKE high through update delays
// R12: Controller holds ODT low if termination enabled
// R13: Controller rewrites mode registers after exit delay
// R14: Controller follows DLL-on switching order
// R15: Controller holds CKE, ODT until DLL lock
// R16: Controller clears A0, then resets DLL
// R17: Long calibration only after update delay
// R18: No locked-DLL command before lock time
// R19: Cycle timings count actual clock edges
// R20: Nanosecond timings round up to cycles
// R21: Controller sequences waits with cycle counters
module ddlo_dll_core #(
  parameter int DLLK_CYC = ddlo_pkg::DLLK_NCK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory command pins
  input wire ddlo_pkg::ddlo_cmd_t cmd,
  // Read timing and DLL status
  output logic rd_dqs_start,
  output logic rd_dq_start,
  output logic dll_off,
  output logic dll_locked,
  output logic in_self_refresh,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ddlo_pkg::ddlo_state_t st; // Registered state
  ddlo_pkg::ddlo_state_t next_st; // Next state
  logic cmd_ok; // A command is registered this edge
  logic rd_cmd; // Read command registered
  logic mrs_cmd; // Mode register set registered
  logic [4:0] lat; // Current read latency in cycles
  logic [4:0] cl; // Decoded CAS latency
  logic [4:0] cwl; // Decoded CAS write latency

  // CAS latency from MR0
  function automatic logic [4:0] cl_dec(input logic [15:0] mr0);
    logic [4:0] base;
    base = mr0[ddlo_pkg::MR0_CL_HI_BIT] ? ddlo_pkg::CL_HI_BASE : ddlo_pkg::CL_BASE;
    return base + {2'b00, mr0[ddlo_pkg::MR0_CL_LSB +: 3]};
  endfunction : cl_dec

  // Read latency; DLL-off starts one cycle early
  function automatic logic [4:0] lat_calc(input logic [4:0] c, input logic [15:0] mr1,
                                          input logic off);
    logic [4:0] al;
    case (mr1[ddlo_pkg::MR1_AL_LSB +: 2])
      2'b01: al = c - 5'h01;
      2'b10: al = c - 5'h02;
      default: al = 5'h00;
    endcase
    return al + c - {4'h0, off}; // [R6]
  endfunction : lat_calc

  // Command decode; deselect and low CKE register nothing
  always_comb begin
    cmd_ok = cmd.cke && !cmd.cs_n && st.ctrl_en && (st.mode == ddlo_pkg::SR_IDLE); // [R1]
    rd_cmd = cmd_ok && ({cmd.ras_n, cmd.cas_n, cmd.we_n} == ddlo_pkg::CMD_READ);
    mrs_cmd = cmd_ok && ({cmd.ras_n, cmd.cas_n, cmd.we_n} == ddlo_pkg::CMD_MRS);
    cl = cl_dec(st.mr0);
    cwl = ddlo_pkg::CWL_BASE + {2'b00, st.mr2[ddlo_pkg::MR2_CWL_LSB +: 3]};
    lat = lat_calc(cl, st.mr1, st.dll_off);
  end

  // Next-state logic for bus, mode registers and read timing
  always_comb begin
    next_st = st;
    // Mode register writes are taken only with commands enabled and outside self refresh
    if (mrs_cmd) begin // [R3]
      case (cmd.ba)
        ddlo_pkg::BA_MR0: begin
          next_st.mr0 = cmd.addr;
        end
        ddlo_pkg::BA_MR1: begin
          next_st.mr1 = cmd.addr;
          next_st.dll_off = cmd.addr[ddlo_pkg::MR1_DLL_BIT]; // [R2]
        end
        ddlo_pkg::BA_MR2: begin
          next_st.mr2 = cmd.addr;
        end
        default: begin
        end
      endcase
    end
    // DLL reset starts a lock count; disabling drops lock
    if (next_st.dll_off) begin
      next_st.dll_locked = 1'b0;
      next_st.lock_cnt = '0;
    end else if (mrs_cmd && cmd.ba == ddlo_pkg::BA_MR0 && cmd.addr[ddlo_pkg::MR0_DLLRST_BIT]) begin
      next_st.dll_locked = 1'b0;
      next_st.lock_cnt = ddlo_pkg::LOCK_W'(DLLK_CYC - 1);
    end else if (st.lock_cnt != '0) begin
      next_st.lock_cnt = st.lock_cnt - 1'b1;
      next_st.dll_locked = (st.lock_cnt == ddlo_pkg::LOCK_W'(1));
    end
    // Self-refresh entry on refresh with CKE low, exit on CKE high
    case (st.mode)
      ddlo_pkg::SR_IDLE: begin
        if (!cmd.cke && !cmd.cs_n
            && {cmd.ras_n, cmd.cas_n, cmd.we_n} == ddlo_pkg::CMD_REF) begin
          next_st.mode = ddlo_pkg::SR_ACTIVE;
        end
      end
      ddlo_pkg::SR_ACTIVE: begin
        if (cmd.cke) begin
          next_st.mode = ddlo_pkg::SR_IDLE;
        end
      end
      default: begin
        next_st.mode = ddlo_pkg::SR_IDLE;
      end
    endcase
    // Read pipeline; strobe and data share one start, so skew is untouched
    next_st.rd_sr = {st.rd_sr[ddlo_pkg::SR_W-2:0], rd_cmd};
    next_st.rd_dqs_start = st.rd_sr[lat - ddlo_pkg::LAT_MIN]; // [R6]
    next_st.rd_dq_start = st.rd_sr[lat - ddlo_pkg::LAT_MIN]; // [R7]
    if (rd_cmd) begin
      next_st.rd_cnt = st.rd_cnt + 1'b1;
    end
    // AXI write address and data, taken in either order
    if (st.awready && s_axi_awvalid) begin
      next_st.aw_done = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.w_done = 1'b1;
      next_st.wdata = s_axi_wdata;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Both halves present: commit and answer
    if (st.aw_done && st.w_done && !st.bvalid) begin
      next_st.aw_done = 1'b0;
      next_st.w_done = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = ddlo_pkg::RESP_OKAY;
      case (st.awaddr)
        ddlo_pkg::CTRL_OFS: begin
          if (s_axi_wstrb[0]) begin
            next_st.ctrl_en = st.wdata[ddlo_pkg::CTRL_EN_BIT];
          end
        end
        ddlo_pkg::STATUS_OFS: begin
          if (s_axi_wstrb[0] && st.wdata[ddlo_pkg::ST_LATERR_BIT]) begin
            next_st.lat_err = 1'b0;
          end
        end
        ddlo_pkg::MR0_OFS, ddlo_pkg::MR1_OFS, ddlo_pkg::MR2_OFS, ddlo_pkg::RDCNT_OFS: begin
        end
        default: begin
          next_st.bresp = ddlo_pkg::RESP_DECERR;
        end
      endcase
    end
    // Unsupported pair while DLL is off; after the clear so set wins
    if (st.dll_off && (cl != ddlo_pkg::DLLOFF_CL || cwl != ddlo_pkg::DLLOFF_CWL)) begin
      next_st.lat_err = 1'b1; // [R5]
    end
    next_st.awready = !next_st.aw_done && !next_st.bvalid;
    next_st.wready = !next_st.w_done && !next_st.bvalid;
    // AXI read
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready && s_axi_arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = ddlo_pkg::RESP_OKAY;
      next_st.rdata = '0;
      case (s_axi_araddr)
        ddlo_pkg::CTRL_OFS: next_st.rdata[ddlo_pkg::CTRL_EN_BIT] = st.ctrl_en;
        ddlo_pkg::STATUS_OFS: begin
          next_st.rdata[ddlo_pkg::ST_DLLOFF_BIT] = st.dll_off;
          next_st.rdata[ddlo_pkg::ST_LOCK_BIT] = st.dll_locked;
          next_st.rdata[ddlo_pkg::ST_SR_BIT] = (st.mode == ddlo_pkg::SR_ACTIVE);
          next_st.rdata[ddlo_pkg::ST_LATERR_BIT] = st.lat_err;
        end
        ddlo_pkg::MR0_OFS: next_st.rdata[15:0] = st.mr0;
        ddlo_pkg::MR1_OFS: next_st.rdata[15:0] = st.mr1;
        ddlo_pkg::MR2_OFS: next_st.rdata[15:0] = st.mr2;
        ddlo_pkg::RDCNT_OFS: next_st.rdata[15:0] = st.rd_cnt;
        default: next_st.rresp = ddlo_pkg::RESP_DECERR;
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl_en <= ddlo_pkg::CTRL_EN_RST;
      st.mr0 <= ddlo_pkg::MR_RST;
      st.mr1 <= ddlo_pkg::MR_RST;
      st.mr2 <= ddlo_pkg::MR_RST;
      st.mode <= ddlo_pkg::SR_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign rd_dqs_start = st.rd_dqs_start;
  assign rd_dq_start = st.rd_dq_start;
  assign dll_off = st.dll_off;
  assign dll_locked = st.dll_locked;
  assign in_self_refresh = st.mode[0]; // Only the active state has bit 0 set
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;

  // Deselect never starts a read
  deselect_block_a: assert property (@(posedge clk) disable iff (rst) // [R1]
    cmd.cs_n |=> !st.rd_sr[0]) else $error("read taken while deselected");
  // MR1 A0 high turns the DLL off
  dll_disable_a: assert property (@(posedge clk) disable iff (rst) // [R2]
    mrs_cmd && cmd.ba == ddlo_pkg::BA_MR1 && cmd.addr[0] |=> st.dll_off && !st.dll_locked)
    else $error("DLL not disabled by MR1 write");
  // DLL state moves only on an MR1 write
  dll_hold_a: assert property (@(posedge clk) disable iff (rst) // [R2]
    !(mrs_cmd && cmd.ba == ddlo_pkg::BA_MR1) |=> $stable(st.dll_off))
    else $error("DLL state changed without MR1 write");
  // A0 cleared re-enables the DLL, outside self refresh and with commands enabled
  dll_enable_a: assert property (@(posedge clk) disable iff (rst) // [R3]
    mrs_cmd && cmd.ba == ddlo_pkg::BA_MR1 && !cmd.addr[0] |=> !st.dll_off)
    else $error("DLL not re-enabled");
  // Unsupported CL flagged while DLL is off; the CWL half is not checked here
  lat_pair_a: assert property (@(posedge clk) disable iff (rst) // [R5]
    st.dll_off && cl != ddlo_pkg::DLLOFF_CL |=> st.lat_err)
    else $error("latency pair not flagged");
  // DLL-off read start at AL+CL-1 with CL 6
  rd_off_lat_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    rd_cmd && st.dll_off && lat == 5'h05 ##1 (lat == 5'h05)[*5] |-> ##0 st.rd_dqs_start)
    else $error("DLL-off read start wrong");
  // DLL-on read start at AL+CL
  rd_on_lat_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    rd_cmd && !st.dll_off && lat == 5'h06 ##1 (lat == 5'h06)[*6] |-> ##0 st.rd_dqs_start)
    else $error("DLL-on read start wrong");
  // Strobe and data start on the same edge
  dqs_dq_align_a: assert property (@(posedge clk) disable iff (rst) // [R7]
    st.rd_dqs_start == st.rd_dq_start) else $error("strobe and data split");

endmodule : ddlo_dll_core

// ---- hw/ddlo_pkg.sv ----
package ddlo_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MR0_OFS = 8'h08;
  localparam logic [7:0] MR1_OFS = 8'h0C;
  localparam logic [7:0] MR2_OFS = 8'h10;
  localparam logic [7:0] RDCNT_OFS = 8'h14;
  // Control and status bit positions
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_DLLOFF_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_SR_BIT = 2;
  localparam int ST_LATERR_BIT = 3;
  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [15:0] MR_RST = 16'h0000;
  // Mode register field positions
  localparam int MR1_DLL_BIT = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR0_DLLRST_BIT = 8;
  localparam int MR0_CL_LSB = 4;
  localparam int MR0_CL_HI_BIT = 2;
  localparam int MR2_CWL_LSB = 3;
  // Latency encodings
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [4:0] CL_HI_BASE = 5'h0C;
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] DLLOFF_CL = 5'h06;
  localparam logic [4:0] DLLOFF_CWL = 5'h06;
  localparam logic [4:0] LAT_MIN = 5'h02;
  // Command codes on ras/cas/we and mode register selects on bank address
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  // DLL lock time in clock cycles
  localparam int DLLK_NCK = 512;
  localparam int LOCK_W = 10;
  localparam int SR_W = 32;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Command/address pins as sampled on the rising clock
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } ddlo_cmd_t;

  // Self-refresh tracking, Gray coded
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_ACTIVE = 2'b01
  } ddlo_sr_t;

  // Whole state of the core
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_done;
    logic w_done;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ctrl_en;
    logic lat_err;
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic dll_off;
    logic dll_locked;
    logic [LOCK_W-1:0] lock_cnt;
    ddlo_sr_t mode;
    logic [SR_W-1:0] rd_sr;
    logic rd_dqs_start;
    logic rd_dq_start;
    logic [15:0] rd_cnt;
  } ddlo_state_t;
endpackage : ddlo_pkg

// ---- tb/ddlo_mc_model.sv ----
`timescale 1ns/1ns
module ddlo_mc_model (
  // Clock
  input wire logic clk,
  // Command pins toward the device
  output ddlo_pkg::ddlo_cmd_t cmd
);
  // CKE level held between commands
  logic cke_hold;

  // Idle is a deselect with CKE high
  initial begin
    cke_hold = 1'b1;
    cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};
  end

  // One command for one edge, then deselect; address flips so stale values never match
  task automatic send(input ddlo_pkg::ddlo_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '{cke_hold, 1'b1, 1'b1, 1'b1, 1'b1, ~c.ba, ~c.addr};
  endtask : send

  // Mode write, then idle so the next one lands five edges later at the earliest
  task automatic mrs(input logic [2:0] ba, input logic [15:0] val);
    send('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, ba, val});
    repeat (3) @(posedge clk);
  endtask : mrs

  // Read, optionally with chip select high
  task automatic rd(input logic cs_n);
    send('{1'b1, cs_n, 1'b1, 1'b0, 1'b1, 3'h0, 16'h0000});
  endtask : rd

  // Self-refresh entry keeps CKE low until exit
  task automatic sre;
    cke_hold = 1'b0;
    send('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 16'h0000});
  endtask : sre

  // Exit, then CKE stays high through later mode updates
  // No termination pin on this link; termination counts as off throughout
  task automatic srx;
    cke_hold = 1'b1;
    send('{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0000});
  endtask : srx
endmodule : ddlo_mc_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  // Clock, reset, device pins and bus
  logic clk, rst;
  ddlo_pkg::ddlo_cmd_t cmd;
  logic dqs_st, dq_st, dll_off, dll_locked, in_sr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata_w;
  int failures = 0;
  int tests_run = 0;

  // Controller model on the command pins
  ddlo_mc_model mc (.clk(clk), .cmd(cmd));

  // Short lock count keeps the run brief
  ddlo_dll_core #(.DLLK_CYC(8)) uut (.clk(clk), .rst(rst), .cmd(cmd),
    .rd_dqs_start(dqs_st), .rd_dq_start(dq_st), .dll_off(dll_off),
    .dll_locked(dll_locked), .in_self_refresh(in_sr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata_w), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 100 MHz clock, one fixed rate kept within the DLL-off ceiling
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and stop
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Four-state compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  // Write; sampling at the falling edge avoids racing the design's own updates
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, rs});
        return;
      end
    end
    failures++;
    end_of_test;
  endtask : axw

  // Read into d and r
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata_w;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    failures++;
    end_of_test;
  endtask : axr

  // Register read and compare
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(nm, e, d);
  endtask : rchk

  // Read command, then count edges to the strobe start; zero means none expected
  task automatic lat_chk(input logic cs_n, input int lat);
    int n;
    mc.rd(cs_n);
    #1;
    for (n = 1; n < 30 && dqs_st !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("read latency", (lat == 0) ? 32'h0000001E : lat, n);
    chk("data start", {31'h0, dqs_st}, {31'h0, dq_st});
    @(posedge clk);
    #1;
    chk("strobe pulse", 32'h00000000, {31'h0, dqs_st});
    // A strobe that never came is a spent wait
    if (lat != 0 && n >= 30) end_of_test;
  endtask : lat_chk

  // Main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Reset values and an unmapped place
    rchk("ctrl", ddlo_pkg::CTRL_OFS, 32'h00000001);
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000000);
    rchk("unmapped", 8'h40, 32'h00000000);
    chk("rresp", {30'h0, ddlo_pkg::RESP_DECERR}, {30'h0, r});
    axw(8'h40, 32'h00000000, ddlo_pkg::RESP_DECERR);
    // DLL on: CL 6, then AL of CL-1
    mc.mrs(ddlo_pkg::BA_MR0, 16'h0020);
    lat_chk(1'b0, 6);
    mc.mrs(ddlo_pkg::BA_MR1, 16'h0008);
    lat_chk(1'b0, 11);
    lat_chk(1'b1, 0);
    // DLL off with CWL 6
    mc.mrs(ddlo_pkg::BA_MR1, 16'h0000);
    mc.mrs(ddlo_pkg::BA_MR2, 16'h0008);
    mc.mrs(ddlo_pkg::BA_MR1, 16'h0001);
    chk("dll off", 32'h00000001, {31'h0, dll_off});
    rchk("mr1 copy", ddlo_pkg::MR1_OFS, 32'h00000001);
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000001);
    lat_chk(1'b0, 5);
    // Unsupported CL while off raises the sticky flag
    mc.mrs(ddlo_pkg::BA_MR0, 16'h0030);
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000009);
    mc.mrs(ddlo_pkg::BA_MR0, 16'h0020);
    axw(ddlo_pkg::STATUS_OFS, 32'h00000008, ddlo_pkg::RESP_OKAY);
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000001);
    // Self refresh round trip
    mc.sre;
    repeat (2) @(posedge clk);
    #1;
    chk("self refresh", 32'h00000001, {31'h0, in_sr});
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000005);
    mc.srx;
    repeat (2) @(posedge clk);
    #1;
    chk("self refresh", 32'h00000000, {31'h0, in_sr});
    // DLL back on, then reset and lock
    mc.mrs(ddlo_pkg::BA_MR1, 16'h0000);
    chk("dll off", 32'h00000000, {31'h0, dll_off});
    mc.mrs(ddlo_pkg::BA_MR0, 16'h0120);
    chk("early lock", 32'h00000000, {31'h0, dll_locked});
    for (int n = 0; n < 12 && dll_locked !== 1'b1; n++) @(posedge clk);
    #1;
    chk("dll lock", 32'h00000001, {31'h0, dll_locked});
    if (dll_locked !== 1'b1) end_of_test;
    rchk("status", ddlo_pkg::STATUS_OFS, 32'h00000002);
    lat_chk(1'b0, 6);
    // Commands disabled, then the read count
    axw(ddlo_pkg::CTRL_OFS, 32'h00000000, ddlo_pkg::RESP_OKAY);
    lat_chk(1'b0, 0);
    axw(ddlo_pkg::CTRL_OFS, 32'h00000001, ddlo_pkg::RESP_OKAY);
    rchk("read count", ddlo_pkg::RDCNT_OFS, 32'h00000004);
    end_of_test;
  end
endmodule : tb_top
